/* File: alj_params.svh */
/*
 * Timing and layout constants of the execution datapath.
 * Assumes inclusion by bare name from the package and the datapath.
 */
`ifndef ALJ_PARAMS_SVH
`define ALJ_PARAMS_SVH

// ==========================================================================
// Cycle counts per instruction class
`define ALJ_CYC_ALU 3'd1
`define ALJ_CYC_WORD 3'd2
`define ALJ_CYC_MUL 3'd2
`define ALJ_CYC_JMP 3'd2
`define ALJ_CYC_CALL 3'd4

// ==========================================================================
// Status flag bit positions
`define ALJ_F_C 0
`define ALJ_F_Z 1
`define ALJ_F_N 2
`define ALJ_F_V 3
`define ALJ_F_S 4
`define ALJ_F_H 5

// ==========================================================================
// Reset values and constants
`define ALJ_SREG_RST 8'h00
`define ALJ_PC_RST 22'h000000
`define ALJ_SP_RST 16'hFFFF
`define ALJ_BYTE_ONES 8'hFF
`define ALJ_FRAC_SHIFT 1

`endif

/* File: alj_pkg.sv */
/*
 * Operation encoding for the execution datapath.
 * Assumes the decoder upstream drives one of these codes per issue.
 */
`include "alj_params.svh"

package alj_pkg;

    // ======================================================================
    // Operations
    typedef enum logic [4:0] {
        OP_ADD, OP_ADD_CARRY, OP_WORD_PLUS_CONSTANT,
        OP_MINUS, OP_MINUS_CONSTANT, OP_MINUS_WITH_BORROW,
        OP_MINUS_CONSTANT_WITH_BORROW, OP_WORD_MINUS_CONSTANT,
        OP_AND, OP_CONJUNCTION_CONSTANT, OP_OR, OP_DISJUNCTION_CONSTANT,
        OP_XOR_REGS, OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK,
        OP_ZERO_MINUS_PROBE, OP_ZERO_REGISTER,
        OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED,
        OP_FRACTION_PRODUCT_UNSIGNED, OP_FRACTION_PRODUCT_SIGNED,
        OP_FRACTION_PRODUCT_MIXED,
        OP_RELATIVE_GOTO, OP_RELATIVE_SUBROUTINE_ENTRY,
        OP_GOTO_VIA_POINTER, OP_GOTO_VIA_EXTENDED_POINTER,
        OP_POINTER_SUBROUTINE_ENTRY, OP_EXTENDED_POINTER_SUBROUTINE_ENTRY
    } alj_op_e;

    typedef enum logic [1:0] {
        ST_IDLE, ST_BUSY
    } alj_state_e;

endpackage : alj_pkg

/* File: alj_datapath.sv */
/*
 * Execution datapath: byte and word arithmetic, logic, multiplies and
 * the relative and indirect jumps and calls, with flags and cycle counts.
 * Assumes a decoder that issues one op when ready is high, holds the
 * operand registers in a 32-entry file here, and a separate stack memory
 * that accepts push strobes with byte data.
 */
`timescale 1ns/1ps
`default_nettype none
`include "alj_params.svh"

module alj_datapath #(
    parameter int PC_W = 22
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Issue port
    input wire logic issue_valid,
    output logic issue_ready,
    input wire alj_pkg::alj_op_e issue_op,
    input wire logic [4:0] dest_sel,
    input wire logic [4:0] source_reg,
    input wire logic [7:0] immediate,
    input wire logic [11:0] rel_offset,
    // Extension byte for extended pointer targets
    input wire logic [7:0] pc_extension_byte,
    // Register file load from the outside datapath
    input wire logic reg_load,
    input wire logic [4:0] reg_load_sel,
    input wire logic [7:0] reg_load_data,
    // Stack push port
    output logic push_valid,
    output logic [7:0] push_data,
    // Observation
    output logic [PC_W-1:0] pc,
    output logic [7:0] status_flags,
    output logic done
);

    // ======================================================================
    // Storage
    logic [7:0] regs_r [32];
    logic [7:0] sreg_r;
    logic [PC_W-1:0] pc_r;
    logic [2:0] cnt_r;
    alj_pkg::alj_state_e state_r;
    alj_pkg::alj_op_e op_r;
    logic [4:0] d_r;
    logic [15:0] wres_r;
    logic [PC_W-1:0] ret_r;
    logic done_r;
    logic push_r;
    logic [7:0] pushd_r;

    // ======================================================================
    // Operand fetch
    logic [7:0] rd;
    logic [7:0] rr;
    logic [15:0] wrd;
    logic [15:0] zptr;
    assign rd = regs_r[dest_sel];
    assign rr = regs_r[source_reg];
    // Low byte at even index, high byte in the next register
    assign wrd = {regs_r[dest_sel + 5'd1], regs_r[dest_sel]};
    assign zptr = {regs_r[31], regs_r[30]};

    // ======================================================================
    // Byte ALU
    logic [7:0] b_opnd;
    logic b_carry_in;
    logic b_sub;
    logic b_logic;
    logic [7:0] b_res;
    logic [8:0] b_sum;
    logic [4:0] b_half;
    logic [7:0] b_flags;
    logic b_write;

    // Select operand and kind of operation for single-cycle byte ops
    always_comb begin
        b_opnd = rr;
        b_carry_in = 1'b0;
        b_sub = 1'b0;
        b_logic = 1'b1;
        b_write = 1'b1;
        b_res = 8'h00;
        case (issue_op)
            alj_pkg::OP_ADD: b_logic = 1'b0;
            alj_pkg::OP_ADD_CARRY: begin
                b_logic = 1'b0;
                b_carry_in = sreg_r[`ALJ_F_C];
            end
            alj_pkg::OP_MINUS: begin
                b_logic = 1'b0;
                b_sub = 1'b1;
            end
            alj_pkg::OP_MINUS_CONSTANT: begin
                b_logic = 1'b0;
                b_sub = 1'b1;
                b_opnd = immediate;
            end
            alj_pkg::OP_MINUS_WITH_BORROW: begin
                b_logic = 1'b0;
                b_sub = 1'b1;
                b_carry_in = sreg_r[`ALJ_F_C];
            end
            alj_pkg::OP_MINUS_CONSTANT_WITH_BORROW: begin
                b_logic = 1'b0;
                b_sub = 1'b1;
                b_opnd = immediate;
                b_carry_in = sreg_r[`ALJ_F_C];
            end
            alj_pkg::OP_AND: b_res = rd & rr;
            alj_pkg::OP_CONJUNCTION_CONSTANT: b_res = rd & immediate;
            alj_pkg::OP_OR: b_res = rd | rr;
            alj_pkg::OP_DISJUNCTION_CONSTANT: b_res = rd | immediate;
            alj_pkg::OP_XOR_REGS: b_res = rd ^ rr;
            alj_pkg::OP_BIT_SET_MASK: b_res = rd | immediate;
            alj_pkg::OP_BIT_CLEAR_MASK:
                b_res = rd & (`ALJ_BYTE_ONES - immediate);
            alj_pkg::OP_ZERO_MINUS_PROBE: b_res = rd & rd;
            alj_pkg::OP_ZERO_REGISTER: b_res = rd ^ rd;
            default: b_write = 1'b0;
        endcase
    end

    // Adder shared by add and subtract; borrow shows as carry out
    assign b_sum = b_sub ? ({1'b0, rd} - {1'b0, b_opnd} - {8'h00, b_carry_in})
                         : ({1'b0, rd} + {1'b0, b_opnd} + {8'h00, b_carry_in});
    assign b_half = b_sub
        ? ({1'b0, rd[3:0]} - {1'b0, b_opnd[3:0]} - {4'h0, b_carry_in})
        : ({1'b0, rd[3:0]} + {1'b0, b_opnd[3:0]} + {4'h0, b_carry_in});

    // Flags for byte ops; logic ops clear V and keep C and H
    always_comb begin
        logic [7:0] r;
        logic v;
        r = b_logic ? b_res : b_sum[7:0];
        v = 1'b0;
        b_flags = sreg_r;
        if (!b_logic) begin
            v = b_sub ? ((rd[7] ^ b_opnd[7]) & (rd[7] ^ r[7]))
                      : (~(rd[7] ^ b_opnd[7]) & (rd[7] ^ r[7]));
            b_flags[`ALJ_F_C] = b_sum[8];
            b_flags[`ALJ_F_H] = b_half[4];
        end
        b_flags[`ALJ_F_Z] = (r == 8'h00);
        b_flags[`ALJ_F_N] = r[7];
        b_flags[`ALJ_F_V] = v;
        b_flags[`ALJ_F_S] = r[7] ^ v;
    end

    // ======================================================================
    // Word ALU and multiplier, computed at issue and stored at finish
    logic [16:0] w_sum;
    logic w_sub;
    logic signed [17:0] m_prod;
    logic [15:0] m_res;
    assign w_sub = (issue_op == alj_pkg::OP_WORD_MINUS_CONSTANT);
    assign w_sum = w_sub ? ({1'b0, wrd} - {9'h000, immediate})
                         : ({1'b0, wrd} + {9'h000, immediate});

    // Operand signedness follows the product kind
    always_comb begin
        logic signed [8:0] a;
        logic signed [8:0] b;
        a = {1'b0, rd};
        b = {1'b0, rr};
        case (issue_op)
            alj_pkg::OP_PRODUCT_SIGNED,
            alj_pkg::OP_FRACTION_PRODUCT_SIGNED: begin
                a = {rd[7], rd};
                b = {rr[7], rr};
            end
            alj_pkg::OP_PRODUCT_MIXED,
            alj_pkg::OP_FRACTION_PRODUCT_MIXED: a = {rd[7], rd};
            default: a = {1'b0, rd};
        endcase
        m_prod = a * b;
    end
    assign m_res = m_prod[15:0];

    // ======================================================================
    // Issue and sequencing
    logic is_word;
    logic is_mul;
    logic is_frac;
    logic is_flow;
    logic is_call;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] pc_next_seq;
    assign is_word = (issue_op == alj_pkg::OP_WORD_PLUS_CONSTANT) || w_sub;
    assign is_mul = (issue_op >= alj_pkg::OP_PRODUCT_UNSIGNED) &&
                    (issue_op <= alj_pkg::OP_FRACTION_PRODUCT_MIXED);
    assign is_frac = (issue_op >= alj_pkg::OP_FRACTION_PRODUCT_UNSIGNED) &&
                     (issue_op <= alj_pkg::OP_FRACTION_PRODUCT_MIXED);
    assign is_flow = (issue_op >= alj_pkg::OP_RELATIVE_GOTO);
    assign is_call = (issue_op == alj_pkg::OP_RELATIVE_SUBROUTINE_ENTRY) ||
        (issue_op == alj_pkg::OP_POINTER_SUBROUTINE_ENTRY) ||
        (issue_op == alj_pkg::OP_EXTENDED_POINTER_SUBROUTINE_ENTRY);
    assign pc_next_seq = pc_r + PC_W'(1);

    // Flow target selection
    always_comb begin
        case (issue_op)
            alj_pkg::OP_GOTO_VIA_POINTER,
            alj_pkg::OP_POINTER_SUBROUTINE_ENTRY:
                target = PC_W'(zptr);
            alj_pkg::OP_GOTO_VIA_EXTENDED_POINTER,
            alj_pkg::OP_EXTENDED_POINTER_SUBROUTINE_ENTRY:
                target = PC_W'({pc_extension_byte, zptr});
            default:
                target = pc_r + PC_W'($signed(rel_offset)) + PC_W'(1);
        endcase
    end

    assign issue_ready = (state_r == alj_pkg::ST_IDLE);

    // Sequencer: multi-cycle ops hold the issue port for their count
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= alj_pkg::ST_IDLE;
            cnt_r <= 3'd0;
            op_r <= alj_pkg::OP_ADD;
            d_r <= 5'd0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (state_r == alj_pkg::ST_IDLE) begin
                if (issue_valid) begin
                    op_r <= issue_op;
                    d_r <= dest_sel;
                    if (is_call) begin
                        state_r <= alj_pkg::ST_BUSY;
                        cnt_r <= `ALJ_CYC_CALL - 3'd1;
                    end else if (is_word || is_mul || is_flow) begin
                        state_r <= alj_pkg::ST_BUSY;
                        cnt_r <= `ALJ_CYC_WORD - 3'd1;
                    end else begin
                        done_r <= 1'b1;
                    end
                end
            end else begin
                cnt_r <= cnt_r - 3'd1;
                if (cnt_r == 3'd1) begin
                    state_r <= alj_pkg::ST_IDLE;
                    done_r <= 1'b1;
                end
            end
        end
    end

    // Word and product results latched at issue, written at the last cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wres_r <= 16'h0000;
        end else if (issue_ready && issue_valid) begin
            if (is_mul) begin
                wres_r <= is_frac ? (m_res << `ALJ_FRAC_SHIFT) : m_res;
            end else begin
                wres_r <= w_sum[15:0];
            end
        end
    end

    // Register file writes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 32; i++) begin
                regs_r[i] <= 8'h00;
            end
        end else if (reg_load) begin
            regs_r[reg_load_sel] <= reg_load_data;
        end else if (issue_ready && issue_valid && b_write) begin
            regs_r[dest_sel] <= b_logic ? b_res : b_sum[7:0];
        end else if (state_r == alj_pkg::ST_BUSY && cnt_r == 3'd1) begin
            if (op_r >= alj_pkg::OP_PRODUCT_UNSIGNED &&
                op_r <= alj_pkg::OP_FRACTION_PRODUCT_MIXED) begin
                regs_r[0] <= wres_r[7:0];
                regs_r[1] <= wres_r[15:8];
            end else if (op_r < alj_pkg::OP_AND) begin
                regs_r[d_r] <= wres_r[7:0];
                regs_r[d_r + 5'd1] <= wres_r[15:8];
            end
        end
    end

    // Status flags; flow ops leave them untouched
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sreg_r <= `ALJ_SREG_RST;
        end else if (issue_ready && issue_valid) begin
            if (b_write) begin
                sreg_r <= b_flags;
            end else if (is_word) begin
                sreg_r[`ALJ_F_Z] <= (w_sum[15:0] == 16'h0000);
                sreg_r[`ALJ_F_C] <= w_sum[16];
                sreg_r[`ALJ_F_N] <= w_sum[15];
                sreg_r[`ALJ_F_V] <= w_sub ? (wrd[15] & ~w_sum[15])
                                          : (~wrd[15] & w_sum[15]);
                sreg_r[`ALJ_F_S] <= w_sum[15] ^ (w_sub
                    ? (wrd[15] & ~w_sum[15]) : (~wrd[15] & w_sum[15]));
            end else if (is_mul) begin
                sreg_r[`ALJ_F_C] <= m_res[15];
                sreg_r[`ALJ_F_Z] <= ((is_frac ? (m_res << `ALJ_FRAC_SHIFT)
                                              : m_res) == 16'h0000);
            end
        end
    end

    // Program counter and return address push, low byte first
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pc_r <= `ALJ_PC_RST;
            ret_r <= `ALJ_PC_RST;
            push_r <= 1'b0;
            pushd_r <= 8'h00;
        end else begin
            push_r <= 1'b0;
            if (issue_ready && issue_valid) begin
                ret_r <= pc_next_seq;
                pc_r <= is_flow ? target : pc_next_seq;
            end else if (state_r == alj_pkg::ST_BUSY &&
                         op_r >= alj_pkg::OP_RELATIVE_GOTO && cnt_r > 3'd1 &&
                         (op_r == alj_pkg::OP_RELATIVE_SUBROUTINE_ENTRY ||
                          op_r >= alj_pkg::OP_POINTER_SUBROUTINE_ENTRY)) begin
                push_r <= 1'b1;
                pushd_r <= (cnt_r == 3'd3) ? ret_r[7:0] : ret_r[15:8];
            end
        end
    end

    assign pc = pc_r;
    assign status_flags = sreg_r;
    assign done = done_r;
    assign push_valid = push_r;
    assign push_data = pushd_r;

    // ======================================================================
    // Checks
    property p_call_len;
        @(posedge clock) disable iff (!arst_n)
        (issue_ready && issue_valid && is_call) |=> !issue_ready [*3] ##1
            issue_ready;
    endproperty
    a_call_len: assert property (p_call_len) else $error("call length");

    property p_word_len;
        @(posedge clock) disable iff (!arst_n)
        (issue_ready && issue_valid && is_word) |-> ##1 !issue_ready ##1 done;
    endproperty
    a_word_len: assert property (p_word_len) else $error("word length");

    // Products hold the issue port for one extra cycle, then report done
    property p_mul_len;
        @(posedge clock) disable iff (!arst_n)
        (issue_ready && issue_valid && is_mul) |=> !issue_ready ##1
            (done && issue_ready);
    endproperty
    a_mul_len: assert property (p_mul_len) else $error("mul length");

    property p_flow_flags;
        @(posedge clock) disable iff (!arst_n)
        (issue_ready && issue_valid && is_flow) |=> $stable(sreg_r);
    endproperty
    a_flow_flags: assert property (p_flow_flags) else $error("flags");

    property p_byte_one;
        @(posedge clock) disable iff (!arst_n)
        (issue_ready && issue_valid && b_write) |=> done && issue_ready;
    endproperty
    a_byte_one: assert property (p_byte_one) else $error("byte op");

    property p_call_push;
        @(posedge clock) disable iff (!arst_n)
        (issue_ready && issue_valid && is_call) |-> ##2 push_valid ##1
            push_valid;
    endproperty
    a_call_push: assert property (p_call_push) else $error("push");

    property p_rel_target;
        @(posedge clock) disable iff (!arst_n)
        (issue_ready && issue_valid && issue_op == alj_pkg::OP_RELATIVE_GOTO)
        |=> pc_r == $past(pc_r) + PC_W'($signed($past(rel_offset)))
            + PC_W'(1);
    endproperty
    a_rel_target: assert property (p_rel_target) else $error("rel");

    property p_ptr_target;
        @(posedge clock) disable iff (!arst_n)
        (issue_ready && issue_valid && !reg_load &&
         issue_op == alj_pkg::OP_GOTO_VIA_POINTER) |=> pc_r == PC_W'($past(zptr));
    endproperty
    a_ptr_target: assert property (p_ptr_target) else $error("ptr");

    property p_zero_reg;
        @(posedge clock) disable iff (!arst_n)
        (issue_ready && issue_valid && !reg_load &&
         issue_op == alj_pkg::OP_ZERO_REGISTER) |=> sreg_r[`ALJ_F_Z];
    endproperty
    a_zero_reg: assert property (p_zero_reg) else $error("clear");

endmodule : alj_datapath

`default_nettype wire

/* File: alj_datapath_test.sv */
/*
 * Self-checking bench for the execution datapath: byte and word arithmetic,
 * logic, multiplies, jumps and calls, their flags, cycle counts and pushes.
 * Assumes the design files and alj_params.svh are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "alj_params.svh"

module alj_datapath_test;
    // ======================================================================
    // Stimulus and observation
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic issue_valid = 1'b0;
    logic issue_ready;
    alj_pkg::alj_op_e issue_op = alj_pkg::OP_ADD;
    logic [4:0] dest_sel = 5'h00;
    logic [4:0] source_reg = 5'h00;
    logic [7:0] immediate = 8'h00;
    logic [11:0] rel_offset = 12'h000;
    logic [7:0] pc_extension_byte = 8'h00;
    logic reg_load = 1'b0;
    logic [4:0] reg_load_sel = 5'h00;
    logic [7:0] reg_load_data = 8'h00;
    logic push_valid;
    logic [7:0] push_data;
    logic [21:0] pc;
    logic [7:0] status_flags;
    logic done;
    int n_mismatch = 0;
    int comparisons = 0;
    int ticks = 0;
    logic [7:0] pushq [$];

    alj_datapath #(.PC_W(22)) alj_datapath_i (
        .clock(clock), .arst_n(arst_n), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .issue_op(issue_op),
        .dest_sel(dest_sel), .source_reg(source_reg),
        .immediate(immediate), .rel_offset(rel_offset),
        .pc_extension_byte(pc_extension_byte), .reg_load(reg_load),
        .reg_load_sel(reg_load_sel), .reg_load_data(reg_load_data),
        .push_valid(push_valid), .push_data(push_data), .pc(pc),
        .status_flags(status_flags), .done(done)
    );

    // ======================================================================
    // Clock, hang guard and push capture
    initial begin
        forever #2.5 clock = ~clock;
    end

    // Whole run needs well under a thousand cycles; this cuts a hang
    always @(posedge clock) begin
        ticks <= ticks + 1;
        if (ticks == 4000) begin
            n_mismatch++;
            summarize();
        end
    end

    // Negedge capture keeps the queue settled before go reads it
    always @(negedge clock) begin
        if (push_valid === 1'b1) pushq.push_back(push_data);
    end

    // ======================================================================
    // Shared tasks
    task automatic summarize();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // Held high across back-to-back loads; go lowers it
    task automatic load(input logic [4:0] sel, input logic [7:0] val);
        reg_load <= 1'b1;
        reg_load_sel <= sel;
        reg_load_data <= val;
        @(posedge clock);
    endtask : load

    // Issues one op; n counts edges until the next op could be taken
    task automatic go(input alj_pkg::alj_op_e op, input int cyc = 1,
                      input logic [15:0] ret = 16'h0000,
                      input logic [4:0] d = 5'h1E,
                      input logic [4:0] r = 5'h10,
                      input logic [7:0] k = 8'h00);
        int n;
        logic seen;
        reg_load <= 1'b0;
        issue_op <= op;
        dest_sel <= d;
        source_reg <= r;
        immediate <= k;
        issue_valid <= 1'b1;
        pushq.delete();
        @(posedge clock);
        issue_valid <= 1'b0;
        n = 1;
        seen = 1'b0;
        forever begin
            #1;
            if (done === 1'b1) seen = 1'b1;
            if (issue_ready === 1'b1 || n >= 9) break;
            @(posedge clock);
            n++;
        end
        cmp(n, cyc);
        cmp(seen, 1'b1);
        if (cyc == `ALJ_CYC_CALL) begin
            cmp(pushq.size(), 2);
            cmp({pushq[1], pushq[0]}, ret);
        end else begin
            cmp(pushq.size(), 0);
        end
        @(posedge clock);
    endtask : go

    task automatic chkf(input logic [7:0] mask, input logic [7:0] exp);
        cmp(status_flags & mask, exp & mask);
    endtask : chkf

    // Reads a register back: subtracting its expected value must give zero
    task automatic chk(input logic [4:0] sel, input logic [7:0] val);
        go(alj_pkg::OP_MINUS_CONSTANT, 1, 16'h0000, sel, 5'h00, val);
        cmp(status_flags[`ALJ_F_Z], 1'b1);
    endtask : chk

    // ======================================================================
    // Scenarios
    task automatic t_add();
        load(5'h1E, 8'h8F);
        load(5'h10, 8'h71);
        load(5'h14, 8'h7F);
        load(5'h15, 8'h00);
        go(alj_pkg::OP_ADD);
        chkf(8'h2F, 8'h23);
        go(alj_pkg::OP_ADD_CARRY, 1, 16'h0000, 5'h14, 5'h15);
        chkf(8'h2F, 8'h2C);
        chk(5'h1E, 8'h00);
        chk(5'h14, 8'h80);
    endtask : t_add

    // Borrow chain: each borrow variant consumes the carry set before it
    task automatic t_sub();
        load(5'h1E, 8'h80);
        load(5'h10, 8'h01);
        load(5'h14, 8'h10);
        load(5'h16, 8'h05);
        load(5'h17, 8'h50);
        load(5'h11, 8'h0F);
        go(alj_pkg::OP_MINUS);
        chkf(8'h2F, 8'h28);
        go(alj_pkg::OP_MINUS_CONSTANT, 1, 16'h0, 5'h14, 5'h10, 8'h20);
        chkf(8'h2F, 8'h05);
        go(alj_pkg::OP_MINUS_CONSTANT_WITH_BORROW, 1, 16'h0, 5'h16, 5'h10,
           8'h0F);
        chkf(8'h2F, 8'h25);
        go(alj_pkg::OP_MINUS_WITH_BORROW, 1, 16'h0, 5'h17, 5'h11);
        chkf(8'h2F, 8'h20);
        chk(5'h1E, 8'h7F);
        chk(5'h14, 8'hF0);
        chk(5'h16, 8'hF5);
        chk(5'h17, 8'h40);
    endtask : t_sub

    // Word results are read back through the pointer jump
    task automatic t_word();
        logic [7:0] f;
        load(5'h1E, 8'hFF);
        load(5'h1F, 8'h00);
        go(alj_pkg::OP_WORD_PLUS_CONSTANT, 2, 16'h0, 5'h1E, 5'h10, 8'h01);
        chkf(8'h1F, 8'h00);
        go(alj_pkg::OP_GOTO_VIA_POINTER, 2);
        cmp(pc, 22'h000100);
        load(5'h1E, 8'h00);
        load(5'h1F, 8'h80);
        go(alj_pkg::OP_WORD_MINUS_CONSTANT, 2, 16'h0, 5'h1E, 5'h10, 8'h01);
        chkf(8'h1F, 8'h18);
        f = status_flags;
        go(alj_pkg::OP_GOTO_VIA_POINTER, 2);
        cmp(pc, 22'h007FFF);
        cmp(status_flags, f);
    endtask : t_word

    // Each case first sets C, H and V so that kept and cleared bits show
    task automatic t_logic();
        alj_pkg::alj_op_e ops [9] = '{alj_pkg::OP_AND,
            alj_pkg::OP_CONJUNCTION_CONSTANT, alj_pkg::OP_OR,
            alj_pkg::OP_DISJUNCTION_CONSTANT, alj_pkg::OP_XOR_REGS,
            alj_pkg::OP_BIT_SET_MASK, alj_pkg::OP_BIT_CLEAR_MASK,
            alj_pkg::OP_ZERO_MINUS_PROBE, alj_pkg::OP_ZERO_REGISTER};
        logic [7:0] res [9] = '{8'h24, 8'h05, 8'hBD, 8'hAF, 8'h99, 8'hAF,
            8'hA0, 8'hA5, 8'h00};
        logic [7:0] flg [9] = '{8'h21, 8'h21, 8'h25, 8'h25, 8'h25, 8'h25,
            8'h25, 8'h25, 8'h23};
        for (int i = 0; i < 9; i++) begin
            load(5'h14, 8'h88);
            load(5'h1E, 8'hA5);
            load(5'h10, 8'h3C);
            go(alj_pkg::OP_ADD, 1, 16'h0, 5'h14, 5'h14);
            go(ops[i], 1, 16'h0, 5'h1E, (i > 6) ? 5'h1E : 5'h10, 8'h0F);
            chkf(8'h2F, flg[i]);
            chk(5'h1E, res[i]);
        end
        cmp(status_flags[`ALJ_F_V], 1'b0);
    endtask : t_logic

    task automatic t_mul();
        alj_pkg::alj_op_e ops [6] = '{alj_pkg::OP_PRODUCT_UNSIGNED,
            alj_pkg::OP_PRODUCT_SIGNED, alj_pkg::OP_PRODUCT_MIXED,
            alj_pkg::OP_FRACTION_PRODUCT_UNSIGNED,
            alj_pkg::OP_FRACTION_PRODUCT_SIGNED,
            alj_pkg::OP_FRACTION_PRODUCT_MIXED};
        logic [15:0] prod [6] = '{16'h7F80, 16'h0080, 16'hFF80, 16'hFF00,
            16'h0100, 16'hFF00};
        logic [7:0] flg [6] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01};
        for (int i = 0; i < 6; i++) begin
            load(5'h10, 8'hFF);
            load(5'h11, 8'h80);
            go(ops[i], 2, 16'h0, 5'h10, 5'h11);
            chkf(8'h03, flg[i]);
            chk(5'h00, prod[i][7:0]);
            chk(5'h01, prod[i][15:8]);
        end
    endtask : t_mul

    task automatic t_jump();
        logic [7:0] f;
        load(5'h1E, 8'h34);
        load(5'h1F, 8'h12);
        go(alj_pkg::OP_GOTO_VIA_POINTER, 2);
        cmp(pc, 22'h001234);
        f = status_flags;
        rel_offset <= 12'hFFE;
        go(alj_pkg::OP_RELATIVE_GOTO, 2);
        cmp(pc, 22'h001233);
        rel_offset <= 12'h005;
        go(alj_pkg::OP_RELATIVE_SUBROUTINE_ENTRY, 4, 16'h1234);
        cmp(pc, 22'h001239);
        go(alj_pkg::OP_POINTER_SUBROUTINE_ENTRY, 4, 16'h123A);
        cmp(pc, 22'h001234);
        pc_extension_byte <= 8'h15;
        go(alj_pkg::OP_GOTO_VIA_EXTENDED_POINTER, 2);
        cmp(pc, 22'h151234);
        load(5'h1E, 8'h78);
        go(alj_pkg::OP_EXTENDED_POINTER_SUBROUTINE_ENTRY, 4, 16'h1235);
        cmp(pc, 22'h151278);
        cmp(status_flags, f);
    endtask : t_jump

    // ======================================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        cmp(pc, `ALJ_PC_RST);
        cmp(status_flags, `ALJ_SREG_RST);
        cmp(issue_ready, 1'b1);
        t_add();
        t_sub();
        t_word();
        t_logic();
        t_mul();
        t_jump();
        summarize();
    end
endmodule : alj_datapath_test
`default_nettype wire
